// file: rtl/mlsf_pkg.sv
// package of constants and carrier types for the monitor limit status flag bank
// assumes a single core_clk domain and an avalon-mm slave with word addresses
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package mlsf_pkg;
    // word offsets on the register bus
    localparam logic [2:0] MLSF_OFF_FLAGS_A = 3'h0;
    localparam logic [2:0] MLSF_OFF_FLAGS_B = 3'h1;
    localparam logic [2:0] MLSF_OFF_CONFIG  = 3'h2;
    localparam logic [2:0] MLSF_OFF_IRQ_ST  = 3'h3;
    localparam logic [2:0] MLSF_OFF_IRQ_MSK = 3'h4;
    // configuration fields
    localparam int         MLSF_CFG_START   = 0;
    localparam int         MLSF_CFG_INIT    = 7;
    localparam logic [7:0] MLSF_CFG_RESET   = 8'h08;
    localparam logic [7:0] MLSF_CFG_WMASK   = 8'h81;
    // flag fields
    localparam int         MLSF_A_VCORE     = 1;
    localparam int         MLSF_A_V3P3      = 2;
    localparam int         MLSF_A_V5        = 3;
    localparam int         MLSF_A_AMB       = 4;
    localparam int         MLSF_A_RMT1      = 5;
    localparam int         MLSF_A_RMT2      = 6;
    localparam int         MLSF_B_V12       = 0;
    localparam logic [7:0] MLSF_A_USED      = 8'h7E;
    localparam logic [7:0] MLSF_B_USED      = 8'h01;
    localparam logic [7:0] MLSF_FLAGS_RESET = 8'h00;
    localparam logic [6:0] MLSF_IRQ_RESET   = 7'h00;
    localparam int         MLSF_NCHAN       = 7;

    // one limit-crossing report per channel, channel order as irq status bits
    typedef struct packed {
        logic v12;
        logic rmt2;
        logic rmt1;
        logic amb;
        logic v5;
        logic v3p3;
        logic vcore;
    } mlsf_chan_t;
endpackage

// file: rtl/mlsf_sticky.sv
// one sticky flag: set by an event, held until clear
// assumes synchronous reset and a single clock
`timescale 1ns/1ps
`default_nettype none
module mlsf_sticky (
    input  wire logic core_clk, // clock
    input  wire logic rst,      // sync reset, active high
    input  wire logic set_in,   // set event
    input  wire logic clr_in,   // clear request
    output logic      flag_r    // held flag
);
    logic flag_nxt;

    // set wins over a clear in the same cycle so no event is lost
    always_comb begin
        flag_nxt = flag_r;
        if (clr_in) begin
            flag_nxt = 1'b0;
        end
        if (set_in) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
endmodule
`default_nettype wire

// file: rtl/mlsf_avs.sv
// avalon-mm slave front end: one-cycle waitrequest on every access
// assumes master holds the request until waitrequest is low
`timescale 1ns/1ps
`default_nettype none
module mlsf_avs (
    input  wire logic core_clk, // clock
    input  wire logic rst,      // sync reset, active high
    input  wire logic read,     // avalon read
    input  wire logic write,    // avalon write
    output logic      waitrequest, // avalon waitrequest
    output logic      rd_go,    // read accepted this cycle
    output logic      wr_go     // write accepted this cycle
);
    logic busy_r;
    logic busy_nxt;

    // first cycle of a request stalls, second completes; decode gets a cycle
    always_comb begin
        busy_nxt = 1'b0;
        if ((read || write) && !busy_r) begin
            busy_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
        end
    end

    assign waitrequest = (read || write) && !busy_r;
    assign rd_go       = read && busy_r;
    assign wr_go       = write && busy_r;
endmodule
`default_nettype wire

// file: rtl/mlsf_top.sv
// limit status flag bank of the hardware monitor, with config and interrupt
// assumes limit reports come from a comparator in the core_clk domain
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mlsf_top
    import mlsf_pkg::*;
(
    input  wire logic       core_clk,          // 10 mhz clock
    input  wire logic       rst,               // sync reset, monitor supply por
    input  wire logic [2:0] address,           // avalon word address
    input  wire logic       read,              // avalon read
    input  wire logic       write,             // avalon write
    input  wire logic [3:0] byteenable,        // avalon byte enables
    input  wire logic [31:0] writedata,        // avalon write data
    output logic [31:0]     readdata,          // avalon read data
    output logic            waitrequest,       // avalon waitrequest
    input  wire mlsf_chan_t limit_hit,         // per-channel limit reached
    output logic            monitor_start,     // start bit, scanning enabled
    output logic            irq                // level interrupt
);
    // ---------------------------------------------------------------------------
    // bus front end
    // ---------------------------------------------------------------------------
    logic rd_go;
    logic wr_go;

    mlsf_avs u_avs (
        .core_clk    (core_clk),
        .rst         (rst),
        .read        (read),
        .write       (write),
        .waitrequest (waitrequest),
        .rd_go       (rd_go),
        .wr_go       (wr_go)
    );

    logic wr_lane0;
    assign wr_lane0 = wr_go && byteenable[0];

    // ---------------------------------------------------------------------------
    // configuration
    // ---------------------------------------------------------------------------
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic       init_pulse;

    // init is taken as a one-cycle pulse, the stored bit never stays set
    assign init_pulse = wr_lane0 && (address == MLSF_OFF_CONFIG) && writedata[MLSF_CFG_INIT];

    always_comb begin
        cfg_nxt = cfg_r;
        if (init_pulse) begin
            cfg_nxt = MLSF_CFG_RESET;
        end else if (wr_lane0 && address == MLSF_OFF_CONFIG) begin
            cfg_nxt = (cfg_r & ~MLSF_CFG_WMASK) | (writedata[7:0] & MLSF_CFG_WMASK & ~8'h80);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_r <= MLSF_CFG_RESET;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    assign monitor_start = cfg_r[MLSF_CFG_START];

    // ---------------------------------------------------------------------------
    // limit flags
    // ---------------------------------------------------------------------------
    logic [MLSF_NCHAN-1:0] hit_vec;
    logic [MLSF_NCHAN-1:0] flag_vec;
    logic [MLSF_NCHAN-1:0] set_vec;

    assign hit_vec = limit_hit;
    // reports ahead of start are dropped, limits may still be loading
    assign set_vec = monitor_start ? hit_vec : '0;

    // sticky until reset or init; software clears them only through init
    genvar gi;
    generate
        for (gi = 0; gi < MLSF_NCHAN; gi++) begin : g_flag
            mlsf_sticky u_flag (
                .core_clk (core_clk),
                .rst      (rst),
                .set_in   (set_vec[gi]),
                .clr_in   (init_pulse),
                .flag_r   (flag_vec[gi])
            );
        end
    endgenerate

    mlsf_chan_t fl;
    assign fl = mlsf_chan_t'(flag_vec);

    logic [7:0] flags_a;
    logic [7:0] flags_b;

    always_comb begin
        flags_a               = MLSF_FLAGS_RESET;
        flags_a[MLSF_A_VCORE] = fl.vcore;
        flags_a[MLSF_A_V3P3]  = fl.v3p3;
        flags_a[MLSF_A_V5]    = fl.v5;
        flags_a[MLSF_A_AMB]   = fl.amb;
        flags_a[MLSF_A_RMT1]  = fl.rmt1;
        flags_a[MLSF_A_RMT2]  = fl.rmt2;
        flags_b               = MLSF_FLAGS_RESET;
        flags_b[MLSF_B_V12]   = fl.v12;
    end

    logic [7:0] three_volt_rail_limit_flag_view;
    assign three_volt_rail_limit_flag_view = flags_a & MLSF_A_USED;

    // ---------------------------------------------------------------------------
    // interrupt status and mask
    // ---------------------------------------------------------------------------
    logic [MLSF_NCHAN-1:0] irq_st_r;
    logic [MLSF_NCHAN-1:0] irq_st_nxt;
    logic [MLSF_NCHAN-1:0] irq_msk_r;
    logic [MLSF_NCHAN-1:0] irq_msk_nxt;
    logic [MLSF_NCHAN-1:0] w1c;

    assign w1c = (wr_lane0 && address == MLSF_OFF_IRQ_ST) ? writedata[MLSF_NCHAN-1:0] : '0;

    // set wins over write-one-to-clear
    always_comb begin
        irq_st_nxt  = (irq_st_r & ~w1c) | set_vec;
        irq_msk_nxt = irq_msk_r;
        if (wr_lane0 && address == MLSF_OFF_IRQ_MSK) begin
            irq_msk_nxt = writedata[MLSF_NCHAN-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_st_r  <= MLSF_IRQ_RESET;
            irq_msk_r <= MLSF_IRQ_RESET;
        end else begin
            irq_st_r  <= irq_st_nxt;
            irq_msk_r <= irq_msk_nxt;
        end
    end

    assign irq = |(irq_st_r & irq_msk_r);

    // ---------------------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------------------
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // writes to the flag offsets have no decode here, so they are ignored
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (address)
            MLSF_OFF_FLAGS_A: rdata_nxt[7:0] = three_volt_rail_limit_flag_view;
            MLSF_OFF_FLAGS_B: rdata_nxt[7:0] = flags_b & MLSF_B_USED;
            MLSF_OFF_CONFIG:  rdata_nxt[7:0] = cfg_r;
            MLSF_OFF_IRQ_ST:  rdata_nxt[MLSF_NCHAN-1:0] = irq_st_r;
            MLSF_OFF_IRQ_MSK: rdata_nxt[MLSF_NCHAN-1:0] = irq_msk_r;
            default:          rdata_nxt = 32'h0000_0000;
        endcase
    end

    // read data is registered in the stall cycle and valid when waitrequest drops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= rdata_r;
        end
    end

    assign readdata = rdata_r;
endmodule
`default_nettype wire

// file: verification/mlsf_top_asserts.sv
// checker of bus timing, reset and start-bit relations at the mlsf_top ports
// assumes a master that holds each request until waitrequest is low
`timescale 1ns/1ps
`default_nettype none
module mlsf_top_asserts (
    input  wire logic        core_clk,      // clock
    input  wire logic        rst,           // sync reset
    input  wire logic [2:0]  address,       // word address
    input  wire logic        read,          // read strobe
    input  wire logic        write,         // write strobe
    input  wire logic [3:0]  byteenable,    // byte enables
    input  wire logic [31:0] writedata,     // write data
    input  wire logic [31:0] readdata,      // read data
    input  wire logic        waitrequest,   // wait
    input  wire logic        monitor_start, // start bit
    input  wire logic        irq            // interrupt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic cfg_wr = write && !waitrequest && address == 3'h2 && byteenable[0];
    wire logic rd_done = read && !waitrequest;

    a_wait_first: assert property ($rose(read || write) |-> waitrequest)
        else $error("no wait state on new request");
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("more than one wait state");
    a_reset_clean: assert property ($fell(rst) |-> !monitor_start && !irq && readdata == 32'h0)
        else $error("outputs not cleared by reset");
    a_a_spare_zero: assert property (rd_done && address == 3'h0 |-> readdata[31:7] == 25'h0 && !readdata[0])
        else $error("unused bits of flags a not zero");
    a_b_spare_zero: assert property (rd_done && address == 3'h1 |-> readdata[31:1] == 31'h0)
        else $error("unused bits of flags b not zero");
    a_start_sets: assert property (cfg_wr && writedata[0] && !writedata[7] |=> monitor_start)
        else $error("start bit not set by write");
    a_init_clears: assert property (cfg_wr && writedata[7] |=> !monitor_start)
        else $error("init did not clear start");
    a_start_holds: assert property (!cfg_wr |=> $stable(monitor_start))
        else $error("start bit changed without config write");

    c_init: cover property (cfg_wr && writedata[7]);
    c_irq: cover property (irq);
    c_flag_b: cover property (rd_done && address == 3'h1 && readdata[0]);
endmodule

bind mlsf_top mlsf_top_asserts mlsf_top_asserts_inst (.core_clk(core_clk), .rst(rst), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .monitor_start(monitor_start), .irq(irq));
`default_nettype wire

// file: verification/monitor_limit_status_flags_bench.sv
// self-checking bench of the flag bank, driven over avalon-mm
// assumes a slave that ends each access by dropping waitrequest, and flags visible one cycle after a hit
`timescale 1ns/1ps
`default_nettype none
module monitor_limit_status_flags_bench;
    import mlsf_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [2:0]  address = 3'h0;
    logic [3:0]  byteenable = 4'h0;
    logic [3:0]  be_cfg = 4'hF;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic [31:0] q;
    logic [31:0] r;
    logic        waitrequest;
    logic        monitor_start;
    logic        irq;
    mlsf_chan_t  limit_hit = '0;
    logic [6:0]  acc;
    int          err_count = 0;
    int          tests_run = 0;
    int          seed = 15;
    int          i;

    always #50 core_clk = ~core_clk;

    mlsf_top mlsf_top_inst (.core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .limit_hit(limit_hit), .monitor_start(monitor_start), .irq(irq));

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request stands until a rising edge sees waitrequest low; data is taken and released at that edge
    task automatic bus(logic wr, logic [2:0] a, logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        byteenable <= be_cfg;
        writedata <= {24'h0, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            err_count++;
            summarize();
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd(logic [2:0] a, string name, logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        check(name, q, exp);
    endtask

    task automatic chk_flags(logic [6:0] c);
        rd(3'h0, "flags_a", {25'h0, c[5:0], 1'b0});
        rd(3'h1, "flags_b", {31'h0, c[6]});
    endtask

    task automatic hit(logic [6:0] v);
        @(posedge core_clk);
        limit_hit <= mlsf_chan_t'(v);
        @(posedge core_clk);
        limit_hit <= '0;
    endtask

    task automatic chk_irq(logic e);
        @(negedge core_clk);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        chk_flags(7'h00);
        rd(3'h2, "config", 32'h08);
        hit(7'h7F);
        chk_flags(7'h00);
        $display("test idle done");
        bus(1'b1, 3'h2, 8'h01);
        acc = 7'h00;
        for (i = 0; i < 7; i++) begin
            hit(7'h01 << i);
            acc |= 7'h01 << i;
            chk_flags(acc);
        end
        bus(1'b1, 3'h0, 8'h00);
        bus(1'b1, 3'h1, 8'h00);
        chk_flags(7'h7F);
        rd(3'h5, "unmapped", 32'h0);
        $display("test channels done");
        bus(1'b1, 3'h4, 8'h7F);
        chk_irq(1'b1);
        bus(1'b1, 3'h4, 8'h00);
        chk_irq(1'b0);
        bus(1'b1, 3'h4, 8'h7F);
        bus(1'b1, 3'h3, 8'h7F);
        chk_irq(1'b0);
        $display("test interrupt done");
        bus(1'b1, 3'h2, 8'h80);
        chk_flags(7'h00);
        rd(3'h2, "config", 32'h08);
        check("start", {31'h0, monitor_start}, 32'h0);
        // a write without lane 0 enabled must leave the start bit alone
        be_cfg = 4'hE;
        bus(1'b1, 3'h2, 8'h01);
        be_cfg = 4'hF;
        rd(3'h2, "config", 32'h08);
        $display("test init done");
        bus(1'b1, 3'h2, 8'h01);
        acc = 7'h00;
        repeat (20) begin
            r = $random(seed);
            hit(r[6:0]);
            acc |= r[6:0];
        end
        chk_flags(acc);
        $display("test random done");
        // reset in mid-run with flags, start, status and mask all set
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        chk_flags(7'h00);
        rd(3'h2, "config", 32'h08);
        chk_irq(1'b0);
        $display("test reset done");
        summarize();
    end
endmodule
`default_nettype wire
